/* rtl/pcabc_pkg.sv */
// Constants and types shared by the counter array time base.
// Assumes an 8-bit special function register bus with page select.
package pcabc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_COUNT_LOW_RELOAD = 8'hCE;
  localparam logic [7:0] ADDR_COUNT_HIGH_RELOAD = 8'hCF;
  localparam logic [7:0] ADDR_ARRAY_RUN_AND_FLAGS = 8'hD8;
  localparam logic [7:0] ADDR_ARRAY_COUNTER_SETUP = 8'hD9;
  localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'hE9;
  localparam logic [7:0] ADDR_MODULE_PWM_AUX6 = 8'hF2;
  localparam logic [7:0] ADDR_MODULE_PWM_AUX7 = 8'hF3;
  localparam logic [7:0] ADDR_COUNT_HIGH_BYTE = 8'hF9;
  localparam logic [3:0] PAGE_CONTROL = 4'h0;
  localparam logic [3:0] PAGE_MODULES_67 = 4'h1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RUN_FLAGS_OVERFLOW_BIT = 7;
  localparam int RUN_FLAGS_RUN_BIT = 6;
  localparam int SETUP_IDLE_GATE_BIT = 7;
  localparam int SETUP_BUF_PAIR45_BIT = 6;
  localparam int SETUP_BUF_PAIR23_BIT = 5;
  localparam int SETUP_BUF_PAIR01_BIT = 4;
  localparam int SETUP_SOURCE_MSB = 3;
  localparam int SETUP_SOURCE_LSB = 1;
  localparam int SETUP_OVF_IRQ_EN_BIT = 0;
  localparam int AUX_EVENT_FLAG_BIT = 3;
  localparam logic [7:0] AUX_WRITE_MASK = 8'hCF;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV12_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Count source codes, in code order 0 to 7
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SYS_DIV12,
    SRC_SYS_DIV2,
    SRC_TIMER0_OVF,
    SRC_EXT_PIN,
    SRC_MIXED_CLOCK,
    SRC_SYS_DIV1,
    SRC_SERIAL_BAUD,
    SRC_MASTER_DIV
  } pcabc_source_type;

  typedef struct packed {
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] rld_lo;
    logic [7:0] rld_hi;
    logic overflow_flag;
    logic count_run;
    logic [5:0] module_event_flag;
    logic [7:0] setup;
    logic [7:0] aux6;
    logic [7:0] aux7;
    logic [3:0] div12;
    logic div2;
    logic toggle_out;
    logic ovf_pulse;
    logic [7:0] rdata;
  } pcabc_state_type;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic fall;
  } pcabc_sync_type;

endpackage

/* rtl/pcabc_pin_sync.sv */
// Two-stage synchroniser with falling edge detect for the count pin.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps
module pcabc_pin_sync (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic fall_o
);

  pcabc_pkg::pcabc_sync_type st_r;
  pcabc_pkg::pcabc_sync_type st_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Edge detect looks only at the second stage and its delayed copy
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pin_i;
    st_nxt.sync = st_r.meta;
    st_nxt.last = st_r.sync;
    st_nxt.fall = st_r.last & ~st_r.sync;
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fall_o = st_r.fall;

endmodule

/* rtl/pcabc_base_counter.sv */
// Shared 16-bit auto-reload time base of the counter array, with its
// run, setup, flag and reload registers on the special function bus.
// Assumes the compare/capture modules sit outside and report matches,
// captures, their mode and their enables as same-clock signals.
//
// Function
// - Sixteen-bit counter from two bytes, reloaded from reload bytes on overflow.
// - Three-bit source field picks one of eight count sources, codes 0 to 7.
// - External source advances the count on each falling pin transition.
// - One sixteen-bit count is the common time base for all modules.
// - Modules 0 to 5 support capture, timer, fast output, PWM, compare-on-PWM.
// - Modules 6 and 7 have all those modes except capture.
// - A module pin stays ordinary I/O while its function does not use it.
// - Counting happens only while run bit 6 of the control register is set.
// - Overflow flag bit 7 set on rollover, cleared only by software, writable.
// - Array interrupt requested while overflow flag and its enable bit 0 set.
// - Module 0 to 5 flags in control bits 0 to 5 set by match or capture.
// - Module 6 and 7 flags in auxiliary bit 3, set on match only.
// - Toggle output flips each overflow, driven onto pin only when enabled.
// - Idle gate bit 7 set stops counting in idle; clear keeps it running.
// - Three pair buffer enables, effective only when both modules qualify.
// - Module flag reaches the interrupt only while its own enable is set.
// - A match sets a module flag only while its match-control bit is 1.
`timescale 1ns/1ps
module pcabc_base_counter (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Special function register access
  input wire logic [3:0] sfr_page_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Count sources on the system clock, except the asynchronous count pin
  input wire logic timer0_overflow_i,
  input wire logic external_count_input_i,
  input wire logic mixed_clock_output_i,
  input wire logic serial_baud_timer_i,
  input wire logic master_clock_divided_i,
  input wire logic idle_mode_i,
  // Compare/capture module side
  input wire logic [7:0] module_match_i,
  input wire logic [5:0] module_capture_i,
  input wire logic [7:0] match_flag_enable_i,
  input wire logic [7:0] module_event_irq_enable_i,
  input wire logic [5:0] module_buffer_capable_i,
  output logic [15:0] count_value_o,
  output logic count_overflow_o,
  output logic [2:0] buffer_enable_pair_o,
  // Toggle output pin
  input wire logic toggle_output_pin_enable_i,
  output logic overflow_toggle_output_o,
  output logic overflow_toggle_output_oe_o,
  output logic array_irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Hardware set wins over a software write in the same cycle
  function automatic logic next_flag(input logic old_val, input logic wr,
                                     input logic wval, input logic evt);
    logic res;
    res = wr ? wval : old_val;
    next_flag = res | evt;
  endfunction

  function automatic logic sel_hit(input logic [3:0] page, input logic [7:0] addr,
                                   input logic [3:0] want_page, input logic [7:0] want_addr);
    sel_hit = (page == want_page) && (addr == want_addr);
  endfunction

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  pcabc_pkg::pcabc_state_type st_r;
  pcabc_pkg::pcabc_state_type st_nxt;

  logic ext_fall;
  logic hit_rld_lo;
  logic hit_rld_hi;
  logic hit_cnt_lo;
  logic hit_cnt_hi;
  logic hit_flags;
  logic hit_setup;
  logic hit_aux6;
  logic hit_aux7;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_flags;
  logic wr_setup;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_aux6;
  logic wr_aux7;
  logic [15:0] count;
  logic [15:0] count_inc;
  logic count_tick;
  logic counting;
  logic overflow_step;
  logic [5:0] flag_events;
  logic [1:0] aux_events;
  logic [7:0] all_flags;
  logic [7:0] read_value;
  pcabc_pkg::pcabc_source_type source;

  // ----------------------------------------------------------------
  // External count pin
  // ----------------------------------------------------------------
  // Two flops and two edge registers: a pin fall counts three cycles late
  pcabc_pin_sync u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .pin_i(external_count_input_i),
    .fall_o(ext_fall)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Reload and count bytes answer on every page, the control pair on the
  // control page only, the module 6/7 slots on their own page only.
  // One decode serves both strobes so reads and writes cannot disagree.
  assign hit_rld_lo = (sfr_addr_i == pcabc_pkg::ADDR_COUNT_LOW_RELOAD);
  assign hit_rld_hi = (sfr_addr_i == pcabc_pkg::ADDR_COUNT_HIGH_RELOAD);
  assign hit_cnt_lo = (sfr_addr_i == pcabc_pkg::ADDR_COUNT_LOW_BYTE);
  assign hit_cnt_hi = (sfr_addr_i == pcabc_pkg::ADDR_COUNT_HIGH_BYTE);
  assign hit_flags = sel_hit(sfr_page_i, sfr_addr_i, pcabc_pkg::PAGE_CONTROL,
                             pcabc_pkg::ADDR_ARRAY_RUN_AND_FLAGS);
  assign hit_setup = sel_hit(sfr_page_i, sfr_addr_i, pcabc_pkg::PAGE_CONTROL,
                             pcabc_pkg::ADDR_ARRAY_COUNTER_SETUP);
  assign hit_aux6 = sel_hit(sfr_page_i, sfr_addr_i, pcabc_pkg::PAGE_MODULES_67,
                            pcabc_pkg::ADDR_MODULE_PWM_AUX6);
  assign hit_aux7 = sel_hit(sfr_page_i, sfr_addr_i, pcabc_pkg::PAGE_MODULES_67,
                            pcabc_pkg::ADDR_MODULE_PWM_AUX7);

  assign wr_rld_lo = sfr_wr_i && hit_rld_lo;
  assign wr_rld_hi = sfr_wr_i && hit_rld_hi;
  assign wr_cnt_lo = sfr_wr_i && hit_cnt_lo;
  assign wr_cnt_hi = sfr_wr_i && hit_cnt_hi;
  assign wr_flags = sfr_wr_i && hit_flags;
  assign wr_setup = sfr_wr_i && hit_setup;
  assign wr_aux6 = sfr_wr_i && hit_aux6;
  assign wr_aux7 = sfr_wr_i && hit_aux7;

  // ----------------------------------------------------------------
  // Count source selection
  // ----------------------------------------------------------------
  assign source = pcabc_pkg::pcabc_source_type'(
                  st_r.setup[pcabc_pkg::SETUP_SOURCE_MSB:pcabc_pkg::SETUP_SOURCE_LSB]);

  // Same-clock ticks need no synchroniser; only the pin is asynchronous.
  // Mixed and divided master clocks arrive as one-cycle ticks from
  // their own generators; faster sources must be divided there first.
  always_comb begin
    count_tick = 1'b0;
    case (source)
      pcabc_pkg::SRC_SYS_DIV12: count_tick = (st_r.div12 == pcabc_pkg::DIV12_LAST);
      pcabc_pkg::SRC_SYS_DIV2: count_tick = st_r.div2;
      pcabc_pkg::SRC_TIMER0_OVF: count_tick = timer0_overflow_i;
      pcabc_pkg::SRC_EXT_PIN: count_tick = ext_fall;
      pcabc_pkg::SRC_MIXED_CLOCK: count_tick = mixed_clock_output_i;
      pcabc_pkg::SRC_SYS_DIV1: count_tick = 1'b1;
      pcabc_pkg::SRC_SERIAL_BAUD: count_tick = serial_baud_timer_i;
      pcabc_pkg::SRC_MASTER_DIV: count_tick = master_clock_divided_i;
      default: count_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter step
  // ----------------------------------------------------------------
  // Reload instead of wrap lets software shorten the period
  // Ticks that arrive while stopped or gated are dropped, not queued
  assign count = {st_r.cnt_hi, st_r.cnt_lo};
  assign count_inc = count + 16'h0001;
  assign counting = st_r.count_run && count_tick &&
                    !(idle_mode_i && st_r.setup[pcabc_pkg::SETUP_IDLE_GATE_BIT]);
  assign overflow_step = counting && (count == pcabc_pkg::COUNT_ALL_ONES);

  // ----------------------------------------------------------------
  // Module events
  // ----------------------------------------------------------------
  // Captures exist only for modules 0 to 5; 6 and 7 have no capture input
  assign flag_events = (module_match_i[5:0] & match_flag_enable_i[5:0]) |
                       module_capture_i;
  assign aux_events = module_match_i[7:6] & match_flag_enable_i[7:6];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ovf_pulse = overflow_step;

    // Free-running prescalers so a source switch picks up cleanly
    if (st_r.div12 == pcabc_pkg::DIV12_LAST) begin
      st_nxt.div12 = pcabc_pkg::DIV12_RESET;
    end else begin
      st_nxt.div12 = st_r.div12 + 4'h1;
    end
    st_nxt.div2 = ~st_r.div2;

    // Reload bytes
    if (wr_rld_lo) begin
      st_nxt.rld_lo = sfr_wdata_i;
    end
    if (wr_rld_hi) begin
      st_nxt.rld_hi = sfr_wdata_i;
    end

    // Count advance; a software byte write overrides the step on that byte
    if (overflow_step) begin
      st_nxt.cnt_hi = st_r.rld_hi;
      st_nxt.cnt_lo = st_r.rld_lo;
      st_nxt.toggle_out = ~st_r.toggle_out;
    end else if (counting) begin
      st_nxt.cnt_hi = count_inc[15:8];
      st_nxt.cnt_lo = count_inc[7:0];
    end
    if (wr_cnt_lo) begin
      st_nxt.cnt_lo = sfr_wdata_i;
    end
    if (wr_cnt_hi) begin
      st_nxt.cnt_hi = sfr_wdata_i;
    end

    // Control register: flags set by hardware win over a clearing write
    st_nxt.overflow_flag = next_flag(st_r.overflow_flag, wr_flags,
                                     sfr_wdata_i[pcabc_pkg::RUN_FLAGS_OVERFLOW_BIT], overflow_step);
    // A tick in the writing cycle still sees the old run bit
    if (wr_flags) begin
      st_nxt.count_run = sfr_wdata_i[pcabc_pkg::RUN_FLAGS_RUN_BIT];
    end
    for (int i = 0; i < 6; i++) begin
      st_nxt.module_event_flag[i] = next_flag(st_r.module_event_flag[i], wr_flags,
                                              sfr_wdata_i[i], flag_events[i]);
    end

    // Setup register
    if (wr_setup) begin
      st_nxt.setup = sfr_wdata_i;
    end

    // Module 6 and 7 auxiliary registers; reserved bits stay zero
    if (wr_aux6) begin
      st_nxt.aux6 = sfr_wdata_i & pcabc_pkg::AUX_WRITE_MASK;
    end
    if (wr_aux7) begin
      st_nxt.aux7 = sfr_wdata_i & pcabc_pkg::AUX_WRITE_MASK;
    end
    st_nxt.aux6[pcabc_pkg::AUX_EVENT_FLAG_BIT] = next_flag(st_r.aux6[pcabc_pkg::AUX_EVENT_FLAG_BIT],
                                                           wr_aux6,
                                                           sfr_wdata_i[pcabc_pkg::AUX_EVENT_FLAG_BIT],
                                                           aux_events[0]);
    st_nxt.aux7[pcabc_pkg::AUX_EVENT_FLAG_BIT] = next_flag(st_r.aux7[pcabc_pkg::AUX_EVENT_FLAG_BIT],
                                                           wr_aux7,
                                                           sfr_wdata_i[pcabc_pkg::AUX_EVENT_FLAG_BIT],
                                                           aux_events[1]);

    // Read data is captured on the strobe and stands until the next read
    if (sfr_rd_i) begin
      st_nxt.rdata = read_value;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Module 6/7 slots answer only on their page so they do not collide
  // with the auxiliary registers of modules 0 and 1.
  always_comb begin
    read_value = pcabc_pkg::RESET_BYTE;
    // Unmapped addresses read zero rather than a stale value
    if (hit_rld_lo) begin
      read_value = st_r.rld_lo;
    end else if (hit_rld_hi) begin
      read_value = st_r.rld_hi;
    end else if (hit_cnt_lo) begin
      read_value = st_r.cnt_lo;
    end else if (hit_cnt_hi) begin
      read_value = st_r.cnt_hi;
    end else if (hit_flags) begin
      read_value = {st_r.overflow_flag, st_r.count_run, st_r.module_event_flag};
    end else if (hit_setup) begin
      read_value = st_r.setup;
    end else if (hit_aux6) begin
      read_value = st_r.aux6;
    end else if (hit_aux7) begin
      read_value = st_r.aux7;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata_o = st_r.rdata;
  assign count_value_o = count;
  assign count_overflow_o = st_r.ovf_pulse;

  // ----------------------------------------------------------------
  // Buffer mode enables
  // ----------------------------------------------------------------
  // A pair with one member in an unsuited mode never sees its enable
  assign buffer_enable_pair_o[0] = st_r.setup[pcabc_pkg::SETUP_BUF_PAIR01_BIT] &&
                                   module_buffer_capable_i[0] && module_buffer_capable_i[1];
  assign buffer_enable_pair_o[1] = st_r.setup[pcabc_pkg::SETUP_BUF_PAIR23_BIT] &&
                                   module_buffer_capable_i[2] && module_buffer_capable_i[3];
  assign buffer_enable_pair_o[2] = st_r.setup[pcabc_pkg::SETUP_BUF_PAIR45_BIT] &&
                                   module_buffer_capable_i[4] && module_buffer_capable_i[5];

  // ----------------------------------------------------------------
  // Toggle output pin
  // ----------------------------------------------------------------
  // Toggle runs with the pin disabled, so enabling it never glitches
  // Pin is released to ordinary I/O whenever the toggle output is off
  assign overflow_toggle_output_o = st_r.toggle_out;
  assign overflow_toggle_output_oe_o = toggle_output_pin_enable_i;

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Level request: stays up until software clears every enabled flag
  assign all_flags = {st_r.aux7[pcabc_pkg::AUX_EVENT_FLAG_BIT],
                      st_r.aux6[pcabc_pkg::AUX_EVENT_FLAG_BIT],
                      st_r.module_event_flag};
  assign array_irq_o = (st_r.overflow_flag && st_r.setup[pcabc_pkg::SETUP_OVF_IRQ_EN_BIT]) ||
                       |(all_flags & module_event_irq_enable_i);

endmodule

/* verification/pcabc_monitor.sv */
// Port-level checker for the counter array time base.
// Assumes it is bound into pcabc_base_counter; one clock domain.
`timescale 1ns/1ps
module pcabc_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] sfr_page_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [5:0] module_buffer_capable_i,
  input wire logic [15:0] count_value_o,
  input wire logic count_overflow_o,
  input wire logic [2:0] buffer_enable_pair_o,
  input wire logic toggle_output_pin_enable_i,
  input wire logic overflow_toggle_output_o,
  input wire logic overflow_toggle_output_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ----
  // Overflow step
  // ----
  a_overflow_from_ones: assert property (count_overflow_o |-> $past(count_value_o) == 16'hFFFF)
    else $error("overflow pulse without an all ones count");
  a_toggle_with_overflow: assert property (count_overflow_o |->
    overflow_toggle_output_o != $past(overflow_toggle_output_o))
    else $error("toggle output did not flip on overflow");
  a_toggle_only_overflow: assert property ($changed(overflow_toggle_output_o) |-> count_overflow_o)
    else $error("toggle output moved without overflow");
  a_flag_after_overflow: assert property (
    (count_overflow_o && sfr_rd_i && sfr_page_i == 4'h0 && sfr_addr_i == 8'hD8) |=> sfr_rdata_o[7])
    else $error("overflow flag not set after rollover");
  // Count moves by one, by reload after all ones, or by a write
  a_count_single_step: assert property (($changed(count_value_o) && !$past(sfr_wr_i)) |->
    (count_value_o == $past(count_value_o) + 16'h0001) || ($past(count_value_o) == pcabc_pkg::COUNT_ALL_ONES))
    else $error("count jumped");
  // ----
  // Register bus and pins
  // ----
  a_rdata_holds: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");
  a_unmapped_reads_zero: assert property ((sfr_rd_i && sfr_addr_i == 8'h00) |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_buffer_needs_pair: assert property (
    (buffer_enable_pair_o & ~{&module_buffer_capable_i[5:4], &module_buffer_capable_i[3:2],
    &module_buffer_capable_i[1:0]}) == 3'h0)
    else $error("buffer enable without both modules capable");
  a_toggle_pin_enable: assert property (overflow_toggle_output_oe_o == toggle_output_pin_enable_i)
    else $error("toggle pin enable wrong");
  c_overflow: cover property (count_overflow_o);
  c_all_pairs: cover property (buffer_enable_pair_o == 3'h7);
  c_flag_read: cover property (count_overflow_o && sfr_rd_i);
endmodule

bind pcabc_base_counter pcabc_monitor mon_u (.sys_clk_i, .sys_rst_i, .sfr_page_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
  .sfr_rdata_o, .module_buffer_capable_i, .count_value_o, .count_overflow_o, .buffer_enable_pair_o,
  .toggle_output_pin_enable_i, .overflow_toggle_output_o, .overflow_toggle_output_oe_o);

/* verification/testbench.sv */
// Self-checking bench for the counter array time base.
// Assumes one 200 MHz clock; all ticks, pins and module events come from here.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] pg = 4'h0;
  logic [7:0] ad = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [3:0] tk = 4'h0;
  logic pin = 1'b0;
  logic idle = 1'b0;
  logic [7:0] mat = 8'h00;
  logic [5:0] cap = 6'h00;
  logic [7:0] mfe = 8'h00;
  logic [7:0] mie = 8'h00;
  logic [5:0] bcap = 6'h00;
  logic pe = 1'b0;
  logic [7:0] rdat;
  logic [15:0] cnt;
  logic ovf;
  logic [2:0] bpair;
  logic tgl;
  logic tgl_oe;
  logic irq;
  logic [15:0] base;
  int s;
  int miscompares = 0;
  int compares = 0;
  int ovfs = 0;
  logic [7:0] map [8] = '{8'hCE, 8'hCF, 8'hD8, 8'hD9, 8'hE9, 8'hF2, 8'hF3, 8'hF9};
  logic [15:0] per_code [8] = '{16'h0002, 16'h000C, 16'h0003, 16'h0003, 16'h0003, 16'h0018, 16'h0003, 16'h0003};
  logic [5:0] caps [6] = '{6'h3F, 6'h15, 6'h2A, 6'h0C, 6'h33, 6'h03};

  always #2.5 clk = ~clk;
  always @(negedge clk) if (ovf === 1'b1) ovfs++;

  pcabc_base_counter dut_u (.sys_clk_i(clk), .sys_rst_i(rst), .sfr_page_i(pg), .sfr_addr_i(ad), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .timer0_overflow_i(tk[0]), .external_count_input_i(pin),
    .mixed_clock_output_i(tk[1]), .serial_baud_timer_i(tk[2]), .master_clock_divided_i(tk[3]),
    .idle_mode_i(idle), .module_match_i(mat), .module_capture_i(cap), .match_flag_enable_i(mfe),
    .module_event_irq_enable_i(mie), .module_buffer_capable_i(bcap), .count_value_o(cnt),
    .count_overflow_o(ovf), .buffer_enable_pair_o(bpair), .toggle_output_pin_enable_i(pe),
    .overflow_toggle_output_o(tgl), .overflow_toggle_output_oe_o(tgl_oe), .array_irq_o(irq));

  // ----
  // Access tasks: each starts and ends on a rising edge
  // ----
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [3:0] p, input logic [7:0] a, input logic [7:0] d);
    {pg, ad, wd, wr} <= {p, a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic r(input logic [3:0] p, input logic [7:0] a, input logic [7:0] e, input string nm);
    {pg, ad, rd} <= {p, a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(nm, {8'h00, e}, {8'h00, rdat});
  endtask
  task automatic step_in(input logic [3:0] t);
    tk <= t;
    @(posedge clk);
    tk <= 4'h0;
    @(posedge clk);
  endtask
  task automatic pulse_mod(input logic [7:0] m, input logic [5:0] c);
    {mat, cap} <= {m, c};
    @(posedge clk);
    {mat, cap} <= 14'h0000;
    @(posedge clk);
  endtask
  // Sampled on falling edges so every counting edge is seen exactly once
  task automatic span(input logic [15:0] e, input string nm);
    @(negedge clk);
    base = cnt;
    repeat (8) @(negedge clk);
    chk(nm, e, cnt - base);
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Whole sequence is about 400 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (map[i]) r((map[i][7:1] == 7'h79) ? 4'h1 : 4'h0, map[i], 8'h00, "reset value");
    r(4'h0, 8'h00, 8'h00, "unmapped");
    w(4'h1, 8'hD8, 8'hFF);
    r(4'h0, 8'hD8, 8'h00, "wrong page");
    w(4'h1, 8'hF2, 8'hFF);
    r(4'h1, 8'hF2, 8'hCF, "aux mask");
    w(4'h1, 8'hF2, 8'h00);
    $display("test registers done");
    w(4'h3, 8'hCE, 8'h34);
    w(4'h5, 8'hCF, 8'h12);
    r(4'h0, 8'hCF, 8'h12, "reload high");
    w(4'h0, 8'hF9, 8'hFF);
    w(4'h0, 8'hE9, 8'hFE);
    w(4'h0, 8'hD9, 8'h05);
    w(4'h0, 8'hD8, 8'h40);
    pe <= 1'b1;
    step_in(4'h1);
    chk("count", 16'hFFFF, cnt);
    // Read the flags in the very cycle of the overflow pulse
    tk <= 4'h1;
    @(posedge clk);
    tk <= 4'h0;
    r(4'h0, 8'hD8, 8'hC0, "flags");
    chk("reload", 16'h1234, cnt);
    chk("toggle", 16'h0001, tgl);
    chk("irq", 16'h0001, irq);
    chk("pulses", 16'h0001, 16'(ovfs));
    chk("pin enable", 16'h0001, tgl_oe);
    step_in(4'h1);
    r(4'h0, 8'hD8, 8'hC0, "flag kept");
    w(4'h0, 8'hD8, 8'h40);
    chk("irq cleared", 16'h0000, irq);
    w(4'h0, 8'hD8, 8'h80);
    r(4'h0, 8'hD8, 8'h80, "soft set");
    chk("irq soft", 16'h0001, irq);
    step_in(4'h1);
    chk("stopped", 16'h1235, cnt);
    w(4'h0, 8'hD9, 8'h04);
    chk("irq masked", 16'h0000, irq);
    w(4'h0, 8'hD8, 8'h00);
    $display("test overflow done");
    for (int c = 0; c < 8; c++) begin
      s = (c == 2) ? 0 : (c == 4) ? 1 : (c >= 6) ? c - 4 : 4;
      w(4'h0, 8'hD9, {4'h0, 3'(c), 1'b0});
      w(4'h0, 8'hD8, 8'h40);
      @(negedge clk);
      base = cnt;
      // The chosen tk input ticks three times; every other tk input runs flat out, the pin always falls three times
      for (int i = 0; i < 24; i++) begin
        @(posedge clk);
        tk <= ~(4'h1 << s) | (((i % 8) == 1) ? (4'h1 << s) : 4'h0);
        pin <= ((i % 8) < 2);
      end
      @(negedge clk);
      chk("source count", per_code[c], cnt - base);
      @(posedge clk);
      {tk, pin} <= 5'h00;
      w(4'h0, 8'hD8, 8'h00);
    end
    $display("test sources done");
    idle <= 1'b1;
    w(4'h0, 8'hD9, 8'h8A);
    w(4'h0, 8'hD8, 8'h40);
    span(16'h0000, "idle gated");
    w(4'h0, 8'hD9, 8'h0A);
    span(16'h0008, "idle running");
    idle <= 1'b0;
    w(4'h0, 8'hD8, 8'h00);
    w(4'h0, 8'hD9, 8'h00);
    $display("test idle done");
    pulse_mod(8'hFF, 6'h00);
    r(4'h0, 8'hD8, 8'h00, "match masked");
    r(4'h1, 8'hF2, 8'h00, "aux masked");
    mfe <= 8'hFF;
    pulse_mod(8'hFF, 6'h00);
    r(4'h0, 8'hD8, 8'h3F, "match flags");
    r(4'h1, 8'hF2, 8'h08, "aux6 flag");
    r(4'h1, 8'hF3, 8'h08, "aux7 flag");
    chk("irq off", 16'h0000, irq);
    mie <= 8'h80;
    @(posedge clk);
    chk("irq module", 16'h0001, irq);
    mfe <= 8'h00;
    w(4'h1, 8'hF3, 8'h00);
    chk("irq flag gone", 16'h0000, irq);
    w(4'h0, 8'hD8, 8'h00);
    w(4'h1, 8'hF2, 8'h00);
    pulse_mod(8'h00, 6'h21);
    r(4'h0, 8'hD8, 8'h21, "capture flags");
    $display("test flags done");
    w(4'h0, 8'hD9, 8'h70);
    foreach (caps[k]) begin
      bcap <= caps[k];
      @(posedge clk);
      chk("pairs", {13'h0000, &caps[k][5:4], &caps[k][3:2], &caps[k][1:0]}, bpair);
    end
    w(4'h0, 8'hD9, 8'h00);
    chk("pairs off", 16'h0000, bpair);
    $display("test buffers done");
    test_done();
  end
endmodule
